/* File: src/parallel_port_cfg.svh */
`ifndef PARALLEL_PORT_CFG_SVH
`define PARALLEL_PORT_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_FIRST_DATA 8'h00
`define OFF_INPUT_DATA 8'h04
`define OFF_SHARED_DATA 8'h08
`define OFF_FIRST_DIR 8'h0c
`define OFF_SHARED_DIR 8'h10
`define OFF_OD_ONE 8'h14
`define OFF_OD_TWO 8'h18
`define OFF_PU_ONE 8'h1c
`define OFF_PU_TWO 8'h20
`define OFF_OPTION 8'h24
`define OFF_KEY_WAKE 8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_OD_FIRST_LOW 0
`define BIT_OD_FIRST_HIGH 1
`define BIT_PU_INPUT_LOW 0
`define BIT_PU_INPUT_HIGH 1
`define BIT_PU_FIRST_LOW 2
`define BIT_PU_FIRST_HIGH 3
`define BIT_OPTION_MAP 0
`define BIT_SHARED_IRQ_TWO 6
`define BIT_SHARED_IRQ_ONE 7
`define BIT_SHARED_EVENT 5
`define BIT_SHARED_EVIN 4
`define BIT_SHARED_CAPTURE 3
`define BIT_SHARED_SCLK 2
`define BIT_SHARED_SOUT 1
`define BIT_SHARED_SIN 0
`define OD_TWO_MASK 8'h3f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_DATA 8'h00
`define RST_DIR 8'h00
`define RST_CTRL 8'h00

`endif

/* File: src/port_pkg.sv */
package port_pkg;

  // Eight-bit port word
  typedef logic [7:0] port_word_t;

  // Register selected by the bus address
  typedef enum logic [3:0] {
    SEL_FIRST_DATA = 4'h0,
    SEL_INPUT_DATA = 4'h1,
    SEL_SHARED_DATA = 4'h2,
    SEL_FIRST_DIR = 4'h3,
    SEL_SHARED_DIR = 4'h4,
    SEL_OD_ONE = 4'h5,
    SEL_OD_TWO = 4'h6,
    SEL_PU_ONE = 4'h7,
    SEL_PU_TWO = 4'h8,
    SEL_OPTION = 4'h9,
    SEL_KEY_WAKE = 4'ha,
    SEL_NONE = 4'hf
  } reg_sel_t;

endpackage

/* File: src/pad_drive.sv */
`timescale 1ns/1ps
module pad_drive #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Per-bit drive request
  input wire logic [W-1:0] drive_en_in,
  input wire logic [W-1:0] drive_val_in,
  input wire logic [W-1:0] od_in,
  input wire logic [W-1:0] pu_sel_in,
  // Pad controls
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_out,
  output logic [W-1:0] pullup_en_out
);

  // ----------------------------------------------------------------
  // One registered driver cell per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic oe_nxt;
      logic pu_nxt;
      // Open drain only ever pulls low; high-side driver is off
      assign oe_nxt = drive_en_in[i] & (~od_in[i] | ~drive_val_in[i]);
      // Pullup drops out whenever the pin is pulled low
      assign pu_nxt = pu_sel_in[i] & ~(oe_nxt & ~drive_val_in[i]);
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          pin_out[i] <= 1'b0;
          pin_oe_out[i] <= 1'b0;
          pullup_en_out[i] <= 1'b0;
        end else begin
          pin_out[i] <= drive_val_in[i];
          pin_oe_out[i] <= oe_nxt;
          pullup_en_out[i] <= pu_nxt;
        end
      end
    end
  endgenerate

endmodule

/* File: src/parallel_port_abc.sv */
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "parallel_port_cfg.svh"
module parallel_port_abc import port_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // First port pins
  input wire logic [7:0] first_pin_in,
  output logic [7:0] first_pin_out,
  output logic [7:0] first_pin_oe_out,
  output logic [7:0] first_pullup_en_out,
  // Input port pins
  input wire logic [7:0] input_pin_in,
  output logic [7:0] input_pullup_en_out,
  // Shared port pins
  input wire logic [7:0] shared_pin_in,
  output logic [7:0] shared_pin_out,
  output logic [7:0] shared_pin_oe_out,
  output logic [7:0] shared_pullup_en_out,
  // Timer and serial peripheral side
  input wire logic timer_event_enable_in,
  input wire logic timer_event_output_in,
  input wire logic serial_unit_enable_in,
  input wire logic serial_master_select_in,
  input wire logic serial_clock_drive_in,
  input wire logic serial_out_pin_in,
  output logic timer_event_input_out,
  output logic timer_capture_input_out,
  output logic serial_clock_sense_out,
  output logic serial_in_pin_out,
  // Interrupt sources and key wakeup
  output logic ext_irq_one_src_out,
  output logic ext_irq_two_src_out,
  output logic [7:0] key_wakeup_enables_out,
  output logic [7:0] key_wakeup_input_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  port_word_t first_data_r;
  port_word_t first_dir_r;
  port_word_t shared_data_r;
  port_word_t shared_dir_r;
  port_word_t od_one_r;
  port_word_t od_two_r;
  port_word_t pu_one_r;
  port_word_t pu_two_r;
  port_word_t key_wake_r;
  logic option_map_r;
  port_word_t first_s1_r;
  port_word_t first_s2_r;
  port_word_t input_s1_r;
  port_word_t input_s2_r;
  port_word_t shared_s1_r;
  port_word_t shared_s2_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  reg_sel_t sel;
  logic access;
  logic wr_en;
  port_word_t wbyte;
  port_word_t first_read;
  port_word_t shared_read;
  port_word_t first_od;
  port_word_t first_pu;
  port_word_t shared_drive_en;
  port_word_t shared_drive_val;
  port_word_t shared_od;
  port_word_t input_pu_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Map the byte address onto a register select
  always_comb begin
    case (paddr_in)
      `OFF_FIRST_DATA: sel = SEL_FIRST_DATA;
      `OFF_INPUT_DATA: sel = SEL_INPUT_DATA;
      `OFF_SHARED_DATA: sel = SEL_SHARED_DATA;
      `OFF_FIRST_DIR: sel = SEL_FIRST_DIR;
      `OFF_SHARED_DIR: sel = SEL_SHARED_DIR;
      `OFF_OD_ONE: sel = SEL_OD_ONE;
      `OFF_OD_TWO: sel = SEL_OD_TWO;
      `OFF_PU_ONE: sel = SEL_PU_ONE;
      `OFF_PU_TWO: sel = SEL_PU_TWO;
      `OFF_OPTION: sel = SEL_OPTION;
      `OFF_KEY_WAKE: sel = SEL_KEY_WAKE;
      default: sel = SEL_NONE;
    endcase
  end

  // Access phase and the completing write edge
  assign access = psel_in & penable_in;
  assign wr_en = access & pwrite_in & pready_r;
  assign wbyte = pwdata_in[7:0];

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access & ~pready_r;
    end
  end

  // Read data and error are captured with ready
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (access & ~pready_r) begin
      prdata_r <= pwrite_in ? 32'h0000_0000 : prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end else begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  assign pready_out = pready_r;
  assign prdata_out = prdata_r;
  assign pslverr_out = pslverr_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages per pin before any use
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_s1_r <= 8'h00;
      first_s2_r <= 8'h00;
      input_s1_r <= 8'h00;
      input_s2_r <= 8'h00;
      shared_s1_r <= 8'h00;
      shared_s2_r <= 8'h00;
    end else begin
      first_s1_r <= first_pin_in;
      first_s2_r <= first_s1_r;
      input_s1_r <= input_pin_in;
      input_s2_r <= input_s1_r;
      shared_s1_r <= shared_pin_in;
      shared_s2_r <= shared_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Data latches always take writes, whatever the pin owner
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_data_r <= `RST_DATA;
      shared_data_r <= `RST_DATA;
    end else if (wr_en) begin
      if (sel == SEL_FIRST_DATA) begin
        first_data_r <= wbyte;
      end
      if (sel == SEL_SHARED_DATA) begin
        shared_data_r <= wbyte;
      end
    end
  end

  // Direction and key wakeup live in the option map
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_dir_r <= `RST_DIR;
      shared_dir_r <= `RST_DIR;
      key_wake_r <= `RST_CTRL;
    end else if (wr_en & option_map_r) begin
      if (sel == SEL_FIRST_DIR) begin
        first_dir_r <= wbyte;
      end
      if (sel == SEL_SHARED_DIR) begin
        shared_dir_r <= wbyte;
      end
      if (sel == SEL_KEY_WAKE) begin
        key_wake_r <= wbyte;
      end
    end
  end

  // Open-drain, pullup and option controls
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      od_one_r <= `RST_CTRL;
      od_two_r <= `RST_CTRL;
      pu_one_r <= `RST_CTRL;
      pu_two_r <= `RST_CTRL;
      option_map_r <= 1'b0;
    end else if (wr_en) begin
      if (sel == SEL_OD_ONE) begin
        od_one_r <= wbyte & 8'h03;
      end
      if (sel == SEL_OD_TWO) begin
        od_two_r <= wbyte & `OD_TWO_MASK;
      end
      if (sel == SEL_PU_ONE) begin
        pu_one_r <= wbyte & 8'h0f;
      end
      if (sel == SEL_PU_TWO) begin
        pu_two_r <= wbyte;
      end
      if (sel == SEL_OPTION) begin
        option_map_r <= wbyte[`BIT_OPTION_MAP];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Per-bit read source: latch for outputs, pin for inputs
  assign first_read = (first_dir_r & first_data_r) | (~first_dir_r & first_s2_r);
  assign shared_read = (shared_dir_r & shared_data_r) | (~shared_dir_r & shared_s2_r);

  // Read multiplexer; direction registers hidden outside the option map
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    case (sel)
      SEL_FIRST_DATA: prdata_nxt[7:0] = first_read;
      SEL_INPUT_DATA: prdata_nxt[7:0] = input_s2_r;
      SEL_SHARED_DATA: prdata_nxt[7:0] = shared_read;
      SEL_FIRST_DIR: prdata_nxt[7:0] = option_map_r ? first_dir_r : 8'h00;
      SEL_SHARED_DIR: prdata_nxt[7:0] = option_map_r ? shared_dir_r : 8'h00;
      SEL_OD_ONE: prdata_nxt[7:0] = od_one_r;
      SEL_OD_TWO: prdata_nxt[7:0] = od_two_r;
      SEL_PU_ONE: prdata_nxt[7:0] = pu_one_r;
      SEL_PU_TWO: prdata_nxt[7:0] = pu_two_r;
      SEL_OPTION: prdata_nxt[`BIT_OPTION_MAP] = option_map_r;
      SEL_KEY_WAKE: prdata_nxt[7:0] = option_map_r ? key_wake_r : 8'h00;
      default: pslverr_nxt = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // First port drive
  // ----------------------------------------------------------------
  // Nibble open-drain and pullup selects spread to bits
  assign first_od = {{4{od_one_r[`BIT_OD_FIRST_HIGH]}}, {4{od_one_r[`BIT_OD_FIRST_LOW]}}};
  assign first_pu = {{4{pu_one_r[`BIT_PU_FIRST_HIGH]}}, {4{pu_one_r[`BIT_PU_FIRST_LOW]}}};

  // Direction bit gates the latch onto the pad
  pad_drive #(
    .W(8)
  ) u_first_pad (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .drive_en_in(first_dir_r),
    .drive_val_in(first_data_r),
    .od_in(first_od),
    .pu_sel_in(first_pu),
    .pin_out(first_pin_out),
    .pin_oe_out(first_pin_oe_out),
    .pullup_en_out(first_pullup_en_out)
  );

  // ----------------------------------------------------------------
  // Input port pullups and key wakeup
  // ----------------------------------------------------------------
  assign input_pu_nxt = {{4{pu_one_r[`BIT_PU_INPUT_HIGH]}}, {4{pu_one_r[`BIT_PU_INPUT_LOW]}}};

  // Pullups and gated wakeup inputs, registered
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input_pullup_en_out <= 8'h00;
      key_wakeup_input_out <= 8'h00;
    end else begin
      input_pullup_en_out <= input_pu_nxt;
      key_wakeup_input_out <= input_s2_r & key_wake_r;
    end
  end

  assign key_wakeup_enables_out = key_wake_r;

  // ----------------------------------------------------------------
  // Shared port drive
  // ----------------------------------------------------------------
  // Pin owner per bit: general purpose, event output or serial unit
  always_comb begin
    shared_drive_en = shared_dir_r;
    shared_drive_val = shared_data_r;
    shared_od = od_two_r & `OD_TWO_MASK;
    shared_od[`BIT_SHARED_IRQ_ONE] = 1'b1;
    shared_od[`BIT_SHARED_IRQ_TWO] = 1'b1;
    if (timer_event_enable_in) begin
      shared_drive_en[`BIT_SHARED_EVENT] = 1'b1;
      shared_drive_val[`BIT_SHARED_EVENT] = timer_event_output_in;
    end
    if (serial_unit_enable_in) begin
      shared_drive_en[`BIT_SHARED_SCLK] = serial_master_select_in;
      shared_drive_val[`BIT_SHARED_SCLK] = serial_clock_drive_in;
      shared_drive_en[`BIT_SHARED_SOUT] = 1'b1;
      shared_drive_val[`BIT_SHARED_SOUT] = serial_out_pin_in;
      shared_drive_en[`BIT_SHARED_SIN] = 1'b0;
    end
  end

  // Registered pads with per-bit pullups
  pad_drive #(
    .W(8)
  ) u_shared_pad (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .drive_en_in(shared_drive_en),
    .drive_val_in(shared_drive_val),
    .od_in(shared_od),
    .pu_sel_in(pu_two_r),
    .pin_out(shared_pin_out),
    .pin_oe_out(shared_pin_oe_out),
    .pullup_en_out(shared_pullup_en_out)
  );

  // ----------------------------------------------------------------
  // Peripheral and interrupt feeds
  // ----------------------------------------------------------------
  // Timer and serial lines see the synchronised pins; irq lines see the shared port read value (latch for outputs)
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_event_input_out <= 1'b0;
      timer_capture_input_out <= 1'b0;
      serial_clock_sense_out <= 1'b0;
      serial_in_pin_out <= 1'b0;
      ext_irq_one_src_out <= 1'b0;
      ext_irq_two_src_out <= 1'b0;
    end else begin
      timer_event_input_out <= shared_s2_r[`BIT_SHARED_EVIN];
      timer_capture_input_out <= shared_s2_r[`BIT_SHARED_CAPTURE];
      serial_clock_sense_out <= shared_s2_r[`BIT_SHARED_SCLK];
      serial_in_pin_out <= shared_s2_r[`BIT_SHARED_SIN];
      ext_irq_one_src_out <= shared_read[`BIT_SHARED_IRQ_ONE];
      ext_irq_two_src_out <= shared_read[`BIT_SHARED_IRQ_TWO];
    end
  end

endmodule

/* File: tb/parallel_port_abc_sva.sv */
`timescale 1ns/1ps
module parallel_port_abc_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Bus
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pads
  input wire logic [7:0] first_pin_out,
  input wire logic [7:0] first_pin_oe_out,
  input wire logic [7:0] first_pullup_en_out,
  input wire logic [7:0] shared_pin_in,
  input wire logic [7:0] shared_pin_out,
  input wire logic [7:0] shared_pin_oe_out,
  input wire logic [7:0] shared_pullup_en_out,
  // Peripherals
  input wire logic timer_event_enable_in,
  input wire logic timer_event_output_in,
  input wire logic serial_unit_enable_in,
  input wire logic serial_master_select_in,
  input wire logic timer_event_input_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [1:0] up_r;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Cycles since reset release, so the sync pipe is primed
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_access; psel_in && penable_in; endsequence
  sequence s_slave; serial_unit_enable_in && !serial_master_select_in; endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ready_wait_one: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
    else $error("ready not in second access cycle");
  a_ready_one_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_rdata_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_reset_no_drive: assert property ($rose(rst_b_in) |->
    (first_pin_oe_out | shared_pin_oe_out) == 8'h0)
    else $error("pad driven after reset");
  a_irq_pins_od: assert property ((shared_pin_oe_out[7:6] & shared_pin_out[7:6]) == 2'h0)
    else $error("high drive on irq pins");
  a_pullup_low_off: assert property (
    ((first_pullup_en_out & first_pin_oe_out & ~first_pin_out)
    | (shared_pullup_en_out & shared_pin_oe_out & ~shared_pin_out)) == 8'h0)
    else $error("pullup on a low driven pin");
  a_event_drive: assert property (timer_event_enable_in ##1 timer_event_enable_in |->
    !shared_pin_oe_out[5] || shared_pin_out[5] == $past(timer_event_output_in))
    else $error("event output not on pin");
  a_serial_slave_in: assert property (s_slave ##1 s_slave |->
    (shared_pin_oe_out & 8'h05) == 8'h0)
    else $error("serial input pins driven");
  a_event_in_sync: assert property (up_r == 2'h3 |->
    timer_event_input_out == $past(shared_pin_in[4], 3))
    else $error("event input sync wrong");
endmodule

/* File: tb/pin_board_model.sv */
`timescale 1ns/1ps
module pin_board_model (
  // Clock
  input wire logic clk_in,
  // Device pad controls
  input wire logic [7:0] drv_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pu_in,
  // Board drivers
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_en_in,
  // Resolved wire
  output logic [7:0] level_out
);
  logic [7:0] wobble_r = 8'h55;
  // Floating lines change every cycle so a stale level never passes
  always_ff @(posedge clk_in) begin
    wobble_r <= ~wobble_r;
  end
  // Device driver first, then board driver, then pullup, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i]) level_out[i] = drv_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pu_in[i]) level_out[i] = 1'b1;
      else level_out[i] = wobble_r[i];
    end
  end
endmodule

/* File: tb/parallel_port_abc_tb_top.sv */
`timescale 1ns/1ps
`include "parallel_port_cfg.svh"
module parallel_port_abc_tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0] fa_out, fa_oe, fa_pu, fa_lvl, fa_ext = 8'h00;
  logic [7:0] ib_pu, ib_lvl, ib_ext = 8'h00, sc_out, sc_oe, sc_pu, sc_lvl, sc_ext = 8'h00;
  logic [7:0] sc_en = 8'hff;
  logic ev_en = 1'b0, ev_val = 1'b0, sp_en = 1'b0, sp_mst = 1'b0, sp_clk = 1'b0, sp_out = 1'b0;
  logic ev_in, cap_in, sck_in, sdi_in, irq1, irq2;
  logic [7:0] kw_en, kw_in, d, v, e, m, p;
  int err_count = 0, checked = 0;
  // Clock at 50 ns
  initial forever #25 clk_in = ~clk_in;
  // ----------------------------------------------------------------
  // Design and board
  // ----------------------------------------------------------------
  parallel_port_abc uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .first_pin_in(fa_lvl), .first_pin_out(fa_out), .first_pin_oe_out(fa_oe),
    .first_pullup_en_out(fa_pu), .input_pin_in(ib_lvl), .input_pullup_en_out(ib_pu),
    .shared_pin_in(sc_lvl), .shared_pin_out(sc_out), .shared_pin_oe_out(sc_oe),
    .shared_pullup_en_out(sc_pu), .timer_event_enable_in(ev_en),
    .timer_event_output_in(ev_val), .serial_unit_enable_in(sp_en),
    .serial_master_select_in(sp_mst), .serial_clock_drive_in(sp_clk),
    .serial_out_pin_in(sp_out), .timer_event_input_out(ev_in),
    .timer_capture_input_out(cap_in), .serial_clock_sense_out(sck_in),
    .serial_in_pin_out(sdi_in), .ext_irq_one_src_out(irq1), .ext_irq_two_src_out(irq2),
    .key_wakeup_enables_out(kw_en), .key_wakeup_input_out(kw_in));
  pin_board_model fa_b (.clk_in(clk_in), .drv_in(fa_out), .oe_in(fa_oe), .pu_in(fa_pu),
    .ext_val_in(fa_ext), .ext_en_in(8'hff), .level_out(fa_lvl));
  pin_board_model ib_b (.clk_in(clk_in), .drv_in(8'h00), .oe_in(8'h00), .pu_in(ib_pu),
    .ext_val_in(ib_ext), .ext_en_in(8'hff), .level_out(ib_lvl));
  pin_board_model sc_b (.clk_in(clk_in), .drv_in(sc_out), .oe_in(sc_oe), .pu_in(sc_pu),
    .ext_val_in(sc_ext), .ext_en_in(sc_en), .level_out(sc_lvl));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; ready, read data and error are taken at the rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, ex});
  endtask
  // Idle cycles, ending on a low phase where outputs are settled
  task automatic idle(input int c);
    repeat (c) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  function automatic logic [7:0] nib(input logic [1:0] b);
    return {{4{b[1]}}, {4{b[0]}}};
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    q = $urandom(32'h3504);
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    idle(1);
    chk(fa_oe | sc_oe, 8'h00);
    wr(`OFF_OPTION, 8'h00);
    wr(`OFF_FIRST_DIR, 8'hff);
    wr(`OFF_KEY_WAKE, 8'hff);
    rd_chk(`OFF_FIRST_DIR, 8'h00);
    rd_chk(`OFF_SHARED_DIR, 8'h00);
    wr(`OFF_OPTION, 8'h01);
    rd_chk(`OFF_FIRST_DIR, 8'h00);
    rd_chk(`OFF_SHARED_DIR, 8'h00);
    rd_chk(`OFF_KEY_WAKE, 8'h00);
    for (int k = 0; k < 8; k++) begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      v = 8'($urandom);
      e = 8'($urandom);
      m = 8'($urandom);
      wr(`OFF_FIRST_DATA, v);
      wr(`OFF_FIRST_DIR, d);
      wr(`OFF_OD_ONE, {6'h0, m[1:0]});
      wr(`OFF_PU_ONE, {4'h0, m[5:2]});
      fa_ext <= e;
      ib_ext <= ~e;
      idle(5);
      rd_chk(`OFF_FIRST_DATA, (v & d) | (e & ~d));
      chk(fa_oe, d & ~(nib(m[1:0]) & v));
      chk(fa_out & d, v & d);
      chk(fa_pu, nib(m[5:4]) & ~(d & ~v));
      chk(ib_pu, nib(m[3:2]));
      rd_chk(`OFF_INPUT_DATA, ~e);
    end
    wr(`OFF_INPUT_DATA, 8'h3c);
    m = 8'($urandom);
    wr(`OFF_KEY_WAKE, m);
    idle(5);
    rd_chk(`OFF_INPUT_DATA, ib_ext);
    rd_chk(`OFF_KEY_WAKE, m);
    chk(kw_in, ib_ext & m);
    chk(kw_en, m);
    rd_chk(8'h2c, 8'h00);
    chk(last_err, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      v = 8'($urandom);
      e = 8'($urandom);
      m = 8'($urandom);
      p = 8'($urandom);
      wr(`OFF_SHARED_DATA, v);
      wr(`OFF_SHARED_DIR, d);
      wr(`OFF_OD_TWO, m);
      wr(`OFF_PU_TWO, p);
      sc_ext <= e;
      idle(5);
      rd_chk(`OFF_SHARED_DATA, (v & d) | (e & ~d));
      chk(sc_oe, d & ~({2'b11, m[5:0]} & v));
      chk(sc_pu, p & ~(d & ~v));
      chk({ev_in, cap_in}, sc_lvl[4:3]);
      chk({irq1, irq2}, (v[7:6] & d[7:6]) | (e[7:6] & ~d[7:6]));
    end
    // Board lets go of the shared pins; pullups alone must read high
    wr(`OFF_SHARED_DIR, 8'h00);
    wr(`OFF_PU_TWO, 8'hff);
    sc_en <= 8'h00;
    idle(5);
    rd_chk(`OFF_SHARED_DATA, 8'hff);
    sc_en <= 8'hff;
    wr(`OFF_OD_TWO, 8'h00);
    for (int k = 0; k < 2; k++) begin
      ev_en <= 1'b1;
      ev_val <= k[0];
      wr(`OFF_SHARED_DIR, 8'h20);
      wr(`OFF_SHARED_DATA, {2'h0, ~k[0], 5'h0});
      idle(2);
      chk({sc_oe[5], sc_out[5]}, {1'b1, k[0]});
      rd_chk(`OFF_SHARED_DATA, (e & 8'hdf) | {2'h0, ~k[0], 5'h0});
      wr(`OFF_SHARED_DIR, 8'h00);
      idle(5);
      rd_chk(`OFF_SHARED_DATA, (e & 8'hdf) | {2'h0, k[0], 5'h0});
    end
    ev_en <= 1'b0;
    sp_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      sp_mst <= k[0];
      sp_clk <= 1'($urandom);
      sp_out <= 1'($urandom);
      wr(`OFF_SHARED_DATA, 8'h00);
      idle(4);
      chk(sc_oe[2:0], {k[0], 2'b10});
      chk(sc_out[1], sp_out);
      chk(sdi_in, sc_lvl[0]);
      chk({sc_out[2], sck_in}, {sp_clk, sc_lvl[2]});
    end
    finish_test();
  end
endmodule
bind parallel_port_abc parallel_port_abc_sva sva_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .first_pin_out(first_pin_out),
  .first_pin_oe_out(first_pin_oe_out), .first_pullup_en_out(first_pullup_en_out),
  .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
  .shared_pin_oe_out(shared_pin_oe_out), .shared_pullup_en_out(shared_pullup_en_out),
  .timer_event_enable_in(timer_event_enable_in),
  .timer_event_output_in(timer_event_output_in),
  .serial_unit_enable_in(serial_unit_enable_in),
  .serial_master_select_in(serial_master_select_in),
  .timer_event_input_out(timer_event_input_out));
